// ===== rtc_pkg.sv
// Purpose: constants and types for the calendar clock block
// Assumes: oscillator arrives as a raw pin level sampled on clock
// Notes:   all time fields are two-digit bcd
//
// Contract
// - calendar spans one hundred years, last year 2099
// - count seconds through years, with leap day in February
// - all time and alarm fields bcd, hours 24-hour only
// - alarm matches at second, minute, hour, day or week granularity
// - periodic event every millisecond, second, minute, hour or day
// - alarm and periodic sources merge onto one interrupt line
// - timekeeping runs from 32.768 kHz oscillator, with calibration
// - processor writes synchronised into oscillator timing before effect
// - written value visible two oscillator cycles after the write
// - writes ignored while oscillator disabled
// - own power-on reset initialises the block's registers
// - device reset pin does not touch the block's flops
// - counter and registers kept while core off, except control
// - wake request on alarm, periodic event or wake pin input
// - alarm or periodic event can be driven out on wake pin
// - scratch register keeps software values across device resets
// - direction bit: 0 active-high input, 1 active-low open-drain
package rtc_pkg;

  localparam logic [15:0] SEC_TICKS_M1 = 16'h7fff;
  localparam logic [5:0]  MS_WHOLE     = 6'h20;
  localparam logic [10:0] MS_FRAC      = 11'h300;
  localparam logic [10:0] MS_DEN       = 11'h3e8;

  localparam logic [3:0] ADDR_SEC     = 4'h0;
  localparam logic [3:0] ADDR_MIN     = 4'h1;
  localparam logic [3:0] ADDR_HOUR    = 4'h2;
  localparam logic [3:0] ADDR_WDAY    = 4'h3;
  localparam logic [3:0] ADDR_DATE    = 4'h4;
  localparam logic [3:0] ADDR_MONTH   = 4'h5;
  localparam logic [3:0] ADDR_YEAR    = 4'h6;
  localparam logic [3:0] ADDR_ALM_SEC = 4'h7;
  localparam logic [3:0] ADDR_ALM_MIN = 4'h8;
  localparam logic [3:0] ADDR_ALM_HR  = 4'h9;
  localparam logic [3:0] ADDR_ALM_DAT = 4'ha;
  localparam logic [3:0] ADDR_ALM_WDY = 4'hb;
  localparam logic [3:0] ADDR_CTRL    = 4'hc;
  localparam logic [3:0] ADDR_MODE    = 4'hd;
  localparam logic [3:0] ADDR_CALIB   = 4'he;
  localparam logic [3:0] ADDR_SCRATCH = 4'hf;

  localparam int CTRL_ALM_EN   = 0;
  localparam int CTRL_PER_EN   = 1;
  localparam int CTRL_WAKE_OUT = 2;
  localparam int CTRL_WAKE_DIR = 3;

  localparam logic [7:0] BCD_ZERO  = 8'h00;
  localparam logic [7:0] BCD_ONE   = 8'h01;
  localparam logic [7:0] SEC_MAX   = 8'h59;
  localparam logic [7:0] HOUR_MAX  = 8'h23;
  localparam logic [7:0] WDAY_MAX  = 8'h07;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX  = 8'h99;
  localparam logic [7:0] FEB       = 8'h02;
  localparam logic [7:0] CTRL_RST  = 8'h00;

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] wday;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rtc_time_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] addr;
    logic [7:0] data;
  } rtc_wr_t;

  typedef enum logic [2:0] {
    WR_IDLE  = 3'b001,
    WR_WAIT  = 3'b010,
    WR_APPLY = 3'b100
  } rtc_wr_state_t;

  typedef enum logic [2:0] {
    ALM_SEC  = 3'h0,
    ALM_MIN  = 3'h1,
    ALM_HOUR = 3'h2,
    ALM_DAY  = 3'h3,
    ALM_WEEK = 3'h4
  } rtc_alarm_mode_t;

  typedef enum logic [2:0] {
    PER_MS   = 3'h0,
    PER_SEC  = 3'h1,
    PER_MIN  = 3'h2,
    PER_HOUR = 3'h3,
    PER_DAY  = 3'h4
  } rtc_period_t;

endpackage

// ===== rtc_calendar.sv
// Purpose: bcd calendar clock with alarm, periodic event and wake pin
// Assumes: rstn is the block's own power-on reset, not the device reset
// Notes:   writes go through one pending slot; wrBusy refuses new ones
module rtc_calendar
  import rtc_pkg::*;
(
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic oscPin,
  input  wire logic oscEnable,
  input  wire logic corePowerGood,
  input  wire rtc_wr_t wr,
  input  wire logic clrAlarm,
  input  wire logic clrPeriodic,
  input  wire logic wakePinIn,
  output rtc_time_t timeNow,
  output logic [7:0] scratch,
  output logic wrBusy,
  output logic alarmFlag,
  output logic periodicFlag,
  output logic irq,
  output logic wakePinOut,
  output logic wakePinOeN,
  output logic wakeRequest
);

  rtc_time_t     alarm;
  rtc_wr_state_t wrState;
  logic [3:0]    pendAddr;
  logic [7:0]    pendData;
  logic          pendEdgeSeen;
  logic [7:0]    ctrl;
  logic [7:0]    mode;
  logic [7:0]    calib;
  logic          oscMeta;
  logic          oscSync;
  logic          oscPrev;
  logic          wakeMeta;
  logic          wakeSync;
  logic [15:0]   divCount;
  logic [5:0]    msCount;
  logic [10:0]   msAcc;
  logic          msLong;
  logic          secTick;
  logic          msTick;
  logic          secTickD;
  logic          rollMinD;
  logic          rollHourD;
  logic          rollDateD;

  logic        oscEdge;
  logic        applyWrite;
  logic [15:0] periodM1;
  logic [10:0] msAccSum;
  logic [7:0]  lastDay;
  logic        rollSec;
  logic        rollMin;
  logic        rollHour;
  logic        rollDate;
  logic        rollMonth;
  logic        alarmMatch;
  logic        periodHit;
  logic        wakeEvent;

  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcdInc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcdInc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // years 00..99 stand for 2000..2099, so every fourth year is leap
  function automatic logic [7:0] monthEnd(input logic [7:0] m,
                                          input logic [7:0] y);
    logic [1:0] yMod4;
    yMod4 = {y[4], 1'b0} + y[1:0];
    if (m == FEB) begin
      monthEnd = (yMod4 == 2'h0) ? 8'h29 : 8'h28;
    end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      monthEnd = 8'h30;
    end else begin
      monthEnd = 8'h31;
    end
  endfunction

  // oscillator and wake pin are foreign levels: two flops first
  always_ff @(posedge clock) begin
    if (!rstn) begin
      oscMeta  <= 1'b0;
      oscSync  <= 1'b0;
      oscPrev  <= 1'b0;
      wakeMeta <= 1'b0;
      wakeSync <= 1'b0;
    end else begin
      oscMeta  <= oscPin;
      oscSync  <= oscMeta;
      oscPrev  <= oscSync;
      wakeMeta <= wakePinIn;
      wakeSync <= wakeMeta;
    end
  end

  assign oscEdge    = oscSync & ~oscPrev & oscEnable;
  assign applyWrite = (wrState == WR_APPLY);

  // write slot: held until two oscillator edges have passed
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wrState      <= WR_IDLE;
      pendAddr     <= 4'h0;
      pendData     <= 8'h00;
      pendEdgeSeen <= 1'b0;
      wrBusy       <= 1'b0;
    end else begin
      unique case (wrState)
        WR_IDLE: begin
          if (wr.valid && oscEnable) begin
            wrState      <= WR_WAIT;
            pendAddr     <= wr.addr;
            pendData     <= wr.data;
            pendEdgeSeen <= 1'b0;
            wrBusy       <= 1'b1;
          end
        end
        WR_WAIT: begin
          if (!oscEnable) begin
            wrState <= WR_IDLE;
            wrBusy  <= 1'b0;
          end else if (oscEdge) begin
            pendEdgeSeen <= 1'b1;
            if (pendEdgeSeen) begin
              wrState <= WR_APPLY;
            end
          end
        end
        WR_APPLY: begin
          wrState <= WR_IDLE;
          wrBusy  <= 1'b0;
        end
      endcase
    end
  end

  // calibration stretches or shortens the second by whole cycles
  assign periodM1 = SEC_TICKS_M1 + {{8{calib[7]}}, calib};

  always_ff @(posedge clock) begin
    if (!rstn) begin
      divCount <= 16'h0000;
      secTick  <= 1'b0;
    end else begin
      secTick <= 1'b0;
      if (applyWrite && pendAddr == ADDR_SEC) begin
        divCount <= 16'h0000;
      end else if (oscEdge) begin
        if (divCount >= periodM1) begin
          divCount <= 16'h0000;
          secTick  <= 1'b1;
        end else begin
          divCount <= divCount + 16'h0001;
        end
      end
    end
  end

  // ms of 32 or 33 cycles averages 32.768; realigned every second
  assign msAccSum = msAcc + MS_FRAC;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      msCount <= 6'h00;
      msAcc   <= 11'h000;
      msLong  <= 1'b0;
      msTick  <= 1'b0;
    end else begin
      msTick <= 1'b0;
      if (secTick) begin
        msCount <= 6'h00;
        msAcc   <= 11'h000;
        msLong  <= 1'b0;
      end else if (oscEdge) begin
        if (msCount == MS_WHOLE - 6'h01 + {5'h00, msLong}) begin
          msCount <= 6'h00;
          msTick  <= 1'b1;
          if (msAccSum >= MS_DEN) begin
            msAcc  <= msAccSum - MS_DEN;
            msLong <= 1'b1;
          end else begin
            msAcc  <= msAccSum;
            msLong <= 1'b0;
          end
        end else begin
          msCount <= msCount + 6'h01;
        end
      end
    end
  end

  assign lastDay   = monthEnd(timeNow.month, timeNow.year);
  assign rollSec   = secTick & (timeNow.sec == SEC_MAX);
  assign rollMin   = rollSec & (timeNow.min == SEC_MAX);
  assign rollHour  = rollMin & (timeNow.hour == HOUR_MAX);
  assign rollDate  = rollHour & (timeNow.date >= lastDay);
  assign rollMonth = rollDate & (timeNow.month == MONTH_MAX);

  // a write to a field wins over the tick on that field only
  always_ff @(posedge clock) begin
    if (!rstn) begin
      timeNow.sec   <= BCD_ZERO;
      timeNow.min   <= BCD_ZERO;
      timeNow.hour  <= BCD_ZERO;
      timeNow.wday  <= BCD_ONE;
      timeNow.date  <= BCD_ONE;
      timeNow.month <= BCD_ONE;
      timeNow.year  <= BCD_ZERO;
    end else begin
      if (applyWrite && pendAddr == ADDR_SEC) begin
        timeNow.sec <= pendData;
      end else if (secTick) begin
        timeNow.sec <= rollSec ? BCD_ZERO : bcdInc(timeNow.sec);
      end
      if (applyWrite && pendAddr == ADDR_MIN) begin
        timeNow.min <= pendData;
      end else if (rollSec) begin
        timeNow.min <= rollMin ? BCD_ZERO : bcdInc(timeNow.min);
      end
      if (applyWrite && pendAddr == ADDR_HOUR) begin
        timeNow.hour <= pendData;
      end else if (rollMin) begin
        timeNow.hour <= rollHour ? BCD_ZERO : bcdInc(timeNow.hour);
      end
      if (applyWrite && pendAddr == ADDR_WDAY) begin
        timeNow.wday <= pendData;
      end else if (rollHour) begin
        timeNow.wday <= (timeNow.wday == WDAY_MAX) ? BCD_ONE
                                                   : bcdInc(timeNow.wday);
      end
      if (applyWrite && pendAddr == ADDR_DATE) begin
        timeNow.date <= pendData;
      end else if (rollHour) begin
        timeNow.date <= rollDate ? BCD_ONE : bcdInc(timeNow.date);
      end
      if (applyWrite && pendAddr == ADDR_MONTH) begin
        timeNow.month <= pendData;
      end else if (rollDate) begin
        timeNow.month <= rollMonth ? BCD_ONE : bcdInc(timeNow.month);
      end
      if (applyWrite && pendAddr == ADDR_YEAR) begin
        timeNow.year <= pendData;
      end else if (rollMonth) begin
        timeNow.year <= (timeNow.year == YEAR_MAX) ? BCD_ZERO
                                                   : bcdInc(timeNow.year);
      end
    end
  end

  // alarm, calibration, mode and scratch live through core power-off
  always_ff @(posedge clock) begin
    if (!rstn) begin
      alarm   <= '0;
      mode    <= 8'h00;
      calib   <= 8'h00;
      scratch <= 8'h00;
    end else if (applyWrite) begin
      unique case (pendAddr)
        ADDR_ALM_SEC: alarm.sec  <= pendData;
        ADDR_ALM_MIN: alarm.min  <= pendData;
        ADDR_ALM_HR:  alarm.hour <= pendData;
        ADDR_ALM_DAT: alarm.date <= pendData;
        ADDR_ALM_WDY: alarm.wday <= pendData;
        ADDR_MODE:    mode       <= pendData;
        ADDR_CALIB:   calib      <= pendData;
        ADDR_SCRATCH: scratch    <= pendData;
        default: ;
      endcase
    end
  end

  // control drops to its reset value whenever core power is gone
  always_ff @(posedge clock) begin
    if (!rstn || !corePowerGood) begin
      ctrl <= CTRL_RST;
    end else if (applyWrite && pendAddr == ADDR_CTRL) begin
      ctrl <= pendData;
    end
  end

  // roll pulses delayed so compares see the updated time
  always_ff @(posedge clock) begin
    if (!rstn) begin
      secTickD  <= 1'b0;
      rollMinD  <= 1'b0;
      rollHourD <= 1'b0;
      rollDateD <= 1'b0;
    end else begin
      secTickD  <= secTick;
      rollMinD  <= rollSec;
      rollHourD <= rollMin;
      rollDateD <= rollHour;
    end
  end

  always_comb begin
    alarmMatch = 1'b0;
    unique case (rtc_alarm_mode_t'(mode[2:0]))
      ALM_SEC:  alarmMatch = (timeNow.sec == alarm.sec);
      ALM_MIN:  alarmMatch = (timeNow.sec == alarm.sec)
                           && (timeNow.min == alarm.min);
      ALM_HOUR: alarmMatch = (timeNow.sec == alarm.sec)
                           && (timeNow.min == alarm.min)
                           && (timeNow.hour == alarm.hour);
      ALM_DAY:  alarmMatch = (timeNow.sec == alarm.sec)
                           && (timeNow.min == alarm.min)
                           && (timeNow.hour == alarm.hour)
                           && (timeNow.date == alarm.date);
      ALM_WEEK: alarmMatch = (timeNow.sec == alarm.sec)
                           && (timeNow.min == alarm.min)
                           && (timeNow.hour == alarm.hour)
                           && (timeNow.wday == alarm.wday);
      default:  alarmMatch = 1'b0;
    endcase
  end

  always_comb begin
    periodHit = 1'b0;
    unique case (rtc_period_t'(mode[6:4]))
      PER_MS:   periodHit = msTick;
      PER_SEC:  periodHit = secTickD;
      PER_MIN:  periodHit = rollMinD;
      PER_HOUR: periodHit = rollHourD;
      PER_DAY:  periodHit = rollDateD;
      default:  periodHit = 1'b0;
    endcase
  end

  // sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      alarmFlag    <= 1'b0;
      periodicFlag <= 1'b0;
    end else begin
      alarmFlag    <= (secTickD & alarmMatch) | (alarmFlag & ~clrAlarm);
      periodicFlag <= periodHit | (periodicFlag & ~clrPeriodic);
    end
  end

  assign wakeEvent = (alarmFlag & ctrl[CTRL_ALM_EN])
                   | (periodicFlag & ctrl[CTRL_PER_EN]);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= wakeEvent;
    end
  end

  // open drain: only ever pulls low, never drives high
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wakePinOut  <= 1'b0;
      wakePinOeN  <= 1'b1;
      wakeRequest <= 1'b0;
    end else begin
      wakePinOut  <= 1'b0;
      wakePinOeN  <= ~(ctrl[CTRL_WAKE_DIR] & ctrl[CTRL_WAKE_OUT]
                       & wakeEvent);
      // pin wake only counts in input mode; pulse must span a clock cycle
      wakeRequest <= wakeEvent
                   | (~ctrl[CTRL_WAKE_DIR] & wakeSync);
    end
  end

endmodule

// ===== rtc_calendar_sva.sv
// Purpose: port checks for the calendar clock block
// Assumes: one clock domain, rstn low is the block reset
// Notes:   write bound suits the fast test oscillator
module rtc_calendar_sva
  import rtc_pkg::*;
(
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       oscEnable,
  input wire rtc_wr_t    wr,
  input wire logic       clrAlarm,
  input wire rtc_time_t  timeNow,
  input wire logic [7:0] scratch,
  input wire logic       wrBusy,
  input wire logic       alarmFlag,
  input wire logic       periodicFlag,
  input wire logic       irq,
  input wire logic       wakePinIn,
  input wire logic       wakePinOut,
  input wire logic       wakePinOeN,
  input wire logic       wakeRequest
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  sequence s_take;
    wr.valid && oscEnable && !wrBusy;
  endsequence
  sequence s_slot;
    wrBusy[*3] ##[1:200] !wrBusy;
  endsequence
  property p_write_slot;
    s_take |=> s_slot;
  endproperty
  property p_osc_off;
    !oscEnable |=> !wrBusy;
  endproperty
  property p_scratch_sync;
    $changed(scratch) |-> $past(wrBusy);
  endproperty
  property p_bcd;
    timeNow.sec[3:0] <= 4'h9 && timeNow.sec <= SEC_MAX &&
    timeNow.min <= SEC_MAX && timeNow.hour <= HOUR_MAX;
  endproperty
  property p_year;
    timeNow.year[3:0] <= 4'h9 && timeNow.year <= YEAR_MAX;
  endproperty
  property p_sec_step;
    $changed(timeNow.sec) && !$past(wrBusy) |-> timeNow.sec ==
      (($past(timeNow.sec) == SEC_MAX) ? BCD_ZERO
                                       : bcdInc($past(timeNow.sec)));
  endproperty
  property p_min_carry;
    $changed(timeNow.min) && !$past(wrBusy) |->
      timeNow.sec == BCD_ZERO && $past(timeNow.sec) == SEC_MAX;
  endproperty
  property p_alarm_sticky;
    alarmFlag && !clrAlarm |=> alarmFlag;
  endproperty
  property p_irq_src;
    irq |-> $past(alarmFlag || periodicFlag);
  endproperty
  property p_pin_out;
    !wakePinOeN |-> irq && wakeRequest && !wakePinOut;
  endproperty
  property p_wake_src;
    $rose(wakeRequest) |-> irq || $past(wakePinIn, 2) ||
      $past(wakePinIn, 3) || $past(wakePinIn, 4);
  endproperty

  a_write_slot: assert property (p_write_slot)
    else $error("write slot timing wrong");
  a_osc_off: assert property (p_osc_off)
    else $error("write held with oscillator off");
  a_scratch_sync: assert property (p_scratch_sync)
    else $error("scratch changed outside a write");
  a_bcd: assert property (p_bcd)
    else $error("time field not bcd");
  a_year: assert property (p_year)
    else $error("year out of range");
  a_sec_step: assert property (p_sec_step)
    else $error("seconds stepped wrongly");
  a_min_carry: assert property (p_min_carry)
    else $error("minute moved without seconds carry");
  a_alarm_sticky: assert property (p_alarm_sticky)
    else $error("alarm flag lost");
  a_irq_src: assert property (p_irq_src)
    else $error("irq without a source flag");
  a_pin_out: assert property (p_pin_out)
    else $error("wake pin pulled without event");
  a_wake_src: assert property (p_wake_src)
    else $error("wake request without cause");
endmodule

bind rtc_calendar rtc_calendar_sva u_sva (
  .clock(clock), .rstn(rstn), .oscEnable(oscEnable), .wr(wr),
  .clrAlarm(clrAlarm), .timeNow(timeNow), .scratch(scratch),
  .wrBusy(wrBusy), .alarmFlag(alarmFlag), .periodicFlag(periodicFlag),
  .irq(irq), .wakePinIn(wakePinIn), .wakePinOut(wakePinOut),
  .wakePinOeN(wakePinOeN), .wakeRequest(wakeRequest)
);

// ===== rtc_wake_partner.sv
// Purpose: power manager on the far side of the wake pin
// Assumes: external pull-up on the pin
// Notes:   drive high holds the pin low between pulses; low lets pull-up win
module rtc_wake_partner
#(
  parameter int PULSE_CYC = 3
)
(
  input  wire logic clock,
  input  wire logic drive,
  input  wire logic pulseGo,
  input  wire logic wakePinOut,
  input  wire logic wakePinOeN,
  output logic      pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;

  always @(posedge clock) begin
    if (pulseGo) begin
      cnt <= PULSE_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  always_comb begin
    if (!wakePinOeN) begin
      pinLevel = wakePinOut;
    end else if (drive) begin
      pinLevel = (cnt > 0);
    end else begin
      pinLevel = 1'b1;
    end
  end
endmodule

// ===== rtc_calendar_alarm_wakeup_tb.sv
// Purpose: scenario bench for the calendar clock block
// Assumes: oscillator modelled at a third of the clock rate
// Notes:   one second, shortened by calibration to 32640 oscillator cycles, is run, so the bench is long
module rtc_calendar_alarm_wakeup_tb
  import rtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OSC_P = 3;
  logic clock = 0, rstn = 0, oscPin = 0, oscEnable = 1;
  logic corePowerGood = 1, clrAlarm = 0, clrPeriodic = 0;
  logic pulseGo = 0, drive = 1, pinLevel;
  rtc_wr_t wr = '0;
  rtc_time_t timeNow;
  logic [7:0] scratch;
  logic wrBusy, alarmFlag, periodicFlag, irq;
  logic wakePinOut, wakePinOeN, wakeRequest;
  int fails = 0, testsRun = 0, cyc = 0, oscCnt = 0;

  rtc_calendar uut (.clock(clock), .rstn(rstn), .oscPin(oscPin),
    .oscEnable(oscEnable), .corePowerGood(corePowerGood), .wr(wr),
    .clrAlarm(clrAlarm), .clrPeriodic(clrPeriodic), .wakePinIn(pinLevel),
    .timeNow(timeNow), .scratch(scratch), .wrBusy(wrBusy),
    .alarmFlag(alarmFlag), .periodicFlag(periodicFlag), .irq(irq),
    .wakePinOut(wakePinOut), .wakePinOeN(wakePinOeN),
    .wakeRequest(wakeRequest));
  rtc_wake_partner #(.PULSE_CYC(OSC_P)) farSide (.clock(clock),
    .drive(drive), .pulseGo(pulseGo), .wakePinOut(wakePinOut),
    .wakePinOeN(wakePinOeN), .pinLevel(pinLevel));

  initial begin
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    #1 oscCnt = (oscCnt + 1) % OSC_P;
    oscPin = (oscCnt == 0);
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 100000) begin
      fails++;
      finishTest();
    end
  end

  task automatic cycN(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [55:0] got, input logic [55:0] exp);
    testsRun++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic waitHi(ref logic s, input int lim, output int k);
    k = 0;
    while (s !== 1'b1 && k < lim) begin
      cycN(1);
      k++;
    end
  endtask
  task automatic wrReg(input logic [3:0] a, input logic [7:0] d,
                       output int lat);
    wr = '{valid: 1'b1, addr: a, data: d};
    cycN(1);
    wr.valid = 1'b0;
    lat = 0;
    while (wrBusy !== 1'b0 && lat < 100) begin
      cycN(1);
      lat++;
    end
    cycN(1);
  endtask

  task automatic testReset();
    chk(timeNow, {BCD_ZERO, BCD_ONE, BCD_ONE, BCD_ONE, 24'h00_0000});
    chk({scratch, wrBusy, alarmFlag, periodicFlag, irq, wakePinOut,
         wakePinOeN, wakeRequest}, {8'h00, 7'b000_0010});
    $display("test reset done");
  endtask
  task automatic testWrite();
    int lat;
    wrReg(ADDR_SCRATCH, 8'ha5, lat);
    chk(scratch, 8'ha5);
    chk(lat > OSC_P && lat <= 4 * OSC_P, 1'b1);
    $display("test write done");
  endtask
  task automatic testPeriodic();
    int k;
    wrReg(ADDR_MODE, 8'h00, k);
    wrReg(ADDR_CTRL, 8'h02, k);
    for (int i = 0; i < 2; i++) begin
      clrPeriodic = 1;
      cycN(1);
      clrPeriodic = 0;
      waitHi(periodicFlag, 300, k);
    end
    chk(k + 1 == 32 * OSC_P || k + 1 == 33 * OSC_P, 1'b1);
    cycN(2);
    chk(irq, 1'b1);
    corePowerGood = 0;
    cycN(3);
    chk(irq, 1'b0);
    corePowerGood = 1;
    chk(scratch, 8'ha5);
    $display("test periodic done");
  endtask
  task automatic testOscOff();
    int lat;
    oscEnable = 0;
    cycN(2);
    wrReg(ADDR_SCRATCH, 8'h3c, lat);
    cycN(10);
    chk({scratch, wrBusy}, {8'ha5, 1'b0});
    oscEnable = 1;
    $display("test osc off done");
  endtask
  task automatic testWakeIn();
    int k;
    pulseGo = 1;
    cycN(1);
    pulseGo = 0;
    waitHi(wakeRequest, 12, k);
    chk({k < 12, wakePinOeN}, 2'b11);
    cycN(12);
    chk(wakeRequest, 1'b0);
    $display("test wake in done");
  endtask
  task automatic testRollover();
    // week alarm at wday 01 00:00:00 and day period share one rollover
    logic [3:0] aTab [10] = '{ADDR_CALIB, ADDR_MODE, ADDR_ALM_SEC,
      ADDR_ALM_WDY, ADDR_YEAR, ADDR_MONTH, ADDR_DATE, ADDR_WDAY,
      ADDR_HOUR, ADDR_MIN};
    logic [7:0] dTab [10] = '{8'h80, 8'h44, 8'h00, 8'h01, 8'h99, 8'h12,
      8'h31, 8'h07, 8'h23, 8'h59};
    int k;
    int n;
    n = (32768 - 128) * OSC_P;
    wrReg(ADDR_CTRL, 8'h0d, k);
    drive = 0;
    foreach (aTab[i]) wrReg(aTab[i], dTab[i], k);
    clrPeriodic = 1;
    cycN(1);
    clrPeriodic = 0;
    wrReg(ADDR_SEC, SEC_MAX, k);
    chk(timeNow, {8'h99, 8'h12, 8'h31, 8'h07, 8'h23, 8'h59, 8'h59});
    k = 0;
    while (timeNow.sec === SEC_MAX && k < n + 12) begin
      cycN(1);
      k++;
    end
    chk(k > n - 12 && k < n + 12, 1'b1);
    chk({alarmFlag, periodicFlag}, 2'b00);
    chk(timeNow, {BCD_ZERO, BCD_ONE, BCD_ONE, BCD_ONE,
                  24'h00_0000});
    cycN(3);
    chk({alarmFlag, periodicFlag, irq, wakeRequest, wakePinOeN},
        5'b1_1110);
    chk(pinLevel, 1'b0);
    clrAlarm = 1;
    cycN(1);
    clrAlarm = 0;
    cycN(3);
    chk({alarmFlag, irq, pinLevel}, 3'b001);
    $display("test rollover done");
  endtask

  task automatic finishTest();
    $display("checks %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    cycN(4);
    rstn = 1;
    cycN(1);
    testReset();
    testWrite();
    testPeriodic();
    testOscOff();
    testWakeIn();
    testRollover();
    finishTest();
  end
endmodule
